// >>> sfb_pkg.sv
// Purpose: shared constants and carriers of the serial flash boot sequencer
// Assumes: 100 MHz system clock, single-lane mode 0 serial flash
// Notes:   status byte layout, opcodes, register map and state carrier
package sfb_pkg;
  // ********************
  // Clock figures
  // ********************
  localparam int CLK_KHZ   = 100000;
  localparam int SLOW_KHZ  = 1420;
  localparam int FAST_KHZ  = 30000;
  // Round half periods up so the link never runs above nominal
  localparam int SLOW_HALF = (CLK_KHZ + 2 * SLOW_KHZ - 1) / (2 * SLOW_KHZ);
  localparam int FAST_HALF = (CLK_KHZ + 2 * FAST_KHZ - 1) / (2 * FAST_KHZ);
  localparam int CLK_NS    = 10;
  localparam int DESEL_NS  = 200;
  localparam int DESEL_CYC = (DESEL_NS + CLK_NS - 1) / CLK_NS;
  localparam int DIV_W     = 6;
  localparam int GAP_W     = 5;
  localparam int ADDR_BITS = 24;
  // ********************
  // Status byte and opcodes
  // ********************
  localparam int BUSY_BIT = 0;
  localparam int LATCH_BIT = 1;
  localparam int LOCK_BIT = 7;
  localparam logic [7:0] STAT_CLEAR = 8'h00;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_STAT_RD   = 8'h05;
  localparam logic [7:0] OP_STAT_WR   = 8'h01;
  localparam logic [7:0] OP_READ    = 8'h0B;
  localparam logic [7:0] OP_PROG    = 8'h02;
  localparam logic [7:0] OP_SERASE  = 8'h20;
  localparam logic [7:0] OP_CERASE  = 8'hC7;
  // ********************
  // Register map and fields
  // ********************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_WDAT = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;
  localparam int CSEL_BIT = 4;
  localparam logic [2:0] CMD_READ   = 3'h1;
  localparam logic [2:0] CMD_PROG   = 3'h2;
  localparam logic [2:0] CMD_SERASE = 3'h3;
  localparam logic [2:0] CMD_CERASE = 3'h4;
  localparam logic [2:0] CMD_STAT_RD = 3'h5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ********************
  // Types
  // ********************
  typedef enum logic [2:0] {S_IDLE, S_LSET, S_PWEL, S_SWRITE, S_MAIN, S_PBUSY} sfb_st_t;
  typedef struct packed {
    logic        awvalid; logic [3:0] awaddr; logic wvalid; logic [31:0] wdata;
    logic [3:0]  wstrb;   logic bready; logic arvalid; logic [3:0] araddr; logic rready;
  } sfb_axi_req_t;
  typedef struct packed {
    logic        awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic        arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } sfb_axi_rsp_t;
  typedef struct packed {
    logic       sck; logic mosi; logic [1:0] cs_n;
  } sfb_pins_t;
  typedef struct packed {
    sfb_st_t st; logic boot_done; logic [2:0] cmd; logic csel;
    logic [ADDR_BITS-1:0] addr; logic [7:0] wdat; logic [7:0] stat; logic [7:0] rdat;
    logic fr_act; logic [2:0] bidx; logic [2:0] nbyt; logic [2:0] bitc;
    logic [7:0] sh; logic [7:0] rx; logic [DIV_W-1:0] div; logic [GAP_W-1:0] gap;
    logic [2:0] sync; logic miso_f;
    logic aw_got; logic w_got; logic [3:0] awa; logic [31:0] wd; logic [3:0] ws;
    sfb_axi_rsp_t rsp; sfb_pins_t pins;
  } sfb_state_t;
endpackage : sfb_pkg

// >>> sfb_seq.sv
// Purpose: serial flash sequencer with boot unprotect and AXI4-Lite control
// Assumes: flash keeps its own latch and busy behaviour
// Notes:   one frame at a time; software commands are dropped until boot finishes
//
// Functional notes
// - Fixed single-lane mode 0 protocol always
// - Status bit 0 means flash busy
// - Status bit 1 is write latch
// - Zero protection field removes all protection
// - Status bit 7 is status write lock
// - Only one status byte per command
// - Boot always assumes protection, disables it
// - Boot: latch set, poll, write zero status
// - Latch set and poll before program/erase
// - Slow clock first, fast clock afterwards
// - Boot on select zero, second select
// - Address space covers sixteen megabytes
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module sfb_seq #(
  parameter int SLOW_HALF_P = sfb_pkg::SLOW_HALF,
  parameter int FAST_HALF_P = sfb_pkg::FAST_HALF
) (
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire sfb_pkg::sfb_axi_req_t axi_req,
  output      sfb_pkg::sfb_axi_rsp_t axi_rsp,
  output      sfb_pkg::sfb_pins_t    flash_pins,
  input  wire logic                 miso
);
  import sfb_pkg::*;

  // Sampling on the falling edge needs at least two cycles per half
  if (FAST_HALF_P < 2 || SLOW_HALF_P < FAST_HALF_P || SLOW_HALF_P > 2 ** DIV_W) begin : g_chk
    $error("sfb_seq: unsupported half period");
  end

  sfb_state_t       s;
  sfb_state_t       n;
  logic             tick;
  logic             fend;
  logic [7:0]       rxb;
  logic [7:0]       nb;
  logic [DIV_W-1:0] half_m1;

  function automatic logic is_wr(input logic [2:0] c);
    return c == CMD_PROG || c == CMD_SERASE || c == CMD_CERASE;
  endfunction : is_wr

  function automatic logic [2:0] frame_len(input sfb_st_t st, input logic [2:0] c);
    logic [2:0] l;
    l = 3'h2;
    if (st == S_LSET) begin
      l = 3'h1;
    end else if (st == S_MAIN) begin
      case (c)
        CMD_READ:   l = 3'h6;
        CMD_PROG:   l = 3'h5;
        CMD_SERASE: l = 3'h4;
        CMD_CERASE: l = 3'h1;
        default:    l = 3'h2;
      endcase
    end
    return l;
  endfunction : frame_len

  function automatic logic [7:0] byte_at(input sfb_st_t st, input logic [2:0] c, input logic [2:0] i,
                                         input logic [ADDR_BITS-1:0] a, input logic [7:0] w);
    logic [7:0] b;
    logic       ad;
    b  = 8'h00;
    ad = st == S_MAIN && (c == CMD_READ || c == CMD_PROG || c == CMD_SERASE);
    case (i)
      3'h0: begin
        case (st)
          S_LSET:   b = OP_LATCH_SET;
          S_SWRITE: b = OP_STAT_WR;
          S_MAIN: begin
            case (c)
              CMD_READ:   b = OP_READ;
              CMD_PROG:   b = OP_PROG;
              CMD_SERASE: b = OP_SERASE;
              CMD_CERASE: b = OP_CERASE;
              default:    b = OP_STAT_RD;
            endcase
          end
          default: b = OP_STAT_RD;
        endcase
      end
      3'h1: b = st == S_SWRITE ? STAT_CLEAR : (ad ? a[23:16] : 8'h00);
      3'h2: b = ad ? a[15:8] : 8'h00;
      3'h3: b = ad ? a[7:0] : 8'h00;
      3'h4: b = c == CMD_PROG ? w : 8'h00;
      default: b = 8'h00;
    endcase
    return b;
  endfunction : byte_at

  // ********************
  // Next-state logic
  // ********************
  always_comb begin
    n       = s;
    tick    = 1'b0;
    fend    = 1'b0;
    nb      = 8'h00;
    half_m1 = s.boot_done ? DIV_W'(FAST_HALF_P - 1) : DIV_W'(SLOW_HALF_P - 1);
    // Pin sampling: change accepted once stages two and three agree
    n.sync = {s.sync[1:0], miso};
    if (s.sync[1] == s.sync[2]) begin
      n.miso_f = s.sync[2];
    end
    // Agreed value taken at once: sync latency eats three of the four cycles of a fast bit
    rxb     = {s.rx[6:0], n.miso_f};
    if (s.div == '0) begin
      tick  = s.fr_act;
      n.div = half_m1;
    end else begin
      n.div = s.div - 1'b1;
    end
    if (!s.fr_act && s.gap != '0) begin
      n.gap = s.gap - 1'b1;
    end
    if (tick) begin
      if (!s.pins.sck) begin
        n.pins.sck = 1'b1;
      end else begin
        n.pins.sck = 1'b0;
        n.rx       = rxb;
        if (s.bitc == 3'h7) begin
          n.bitc = 3'h0;
          if (s.bidx == s.nbyt - 3'h1) begin
            fend         = 1'b1;
            n.fr_act     = 1'b0;
            n.pins.cs_n  = 2'b11;
            n.gap        = GAP_W'(DESEL_CYC);
          end else begin
            nb          = byte_at(s.st, s.cmd, s.bidx + 3'h1, s.addr, s.wdat);
            n.bidx      = s.bidx + 3'h1;
            n.sh        = nb;
            n.pins.mosi = nb[7];
          end
        end else begin
          n.bitc      = s.bitc + 3'h1;
          n.sh        = {s.sh[6:0], 1'b0};
          n.pins.mosi = s.sh[6];
        end
      end
    end
    // ********************
    // Sequencer
    // ********************
    if (fend) begin
      case (s.st)
        S_LSET: n.st = S_PWEL;
        S_PWEL: begin
          n.stat = rxb;
          if (rxb[LATCH_BIT]) begin
            n.st = s.boot_done ? S_MAIN : S_SWRITE;
          end
        end
        S_SWRITE: n.st = S_PBUSY;
        S_MAIN: begin
          if (s.cmd == CMD_READ) begin
            n.rdat = rxb;
          end
          if (s.cmd == CMD_STAT_RD) begin
            n.stat = rxb;
          end
          // poll busy after write; latch re-set next time
          n.st = is_wr(s.cmd) ? S_PBUSY : S_IDLE;
        end
        S_PBUSY: begin
          n.stat = rxb;
          if (!rxb[BUSY_BIT]) begin
            n.st        = S_IDLE;
            n.boot_done = 1'b1;
          end
        end
        default: n.st = S_IDLE;
      endcase
    end
    if (s.st != S_IDLE && !s.fr_act && s.gap == '0) begin
      // select low for frame; boot on select zero
      nb          = byte_at(s.st, s.cmd, 3'h0, s.addr, s.wdat);
      n.fr_act    = 1'b1;
      n.pins.cs_n = s.csel ? 2'b01 : 2'b10;
      n.nbyt      = frame_len(s.st, s.cmd);
      n.bidx      = 3'h0;
      n.bitc      = 3'h0;
      n.sh        = nb;
      n.pins.mosi = nb[7];
      n.div       = half_m1;
    end
    // ********************
    // AXI4-Lite slave
    // ********************
    if (s.rsp.bvalid && axi_req.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    if (axi_req.awvalid && s.rsp.awready) begin
      n.aw_got = 1'b1;
      n.awa    = axi_req.awaddr;
    end
    if (axi_req.wvalid && s.rsp.wready) begin
      n.w_got = 1'b1;
      n.wd    = axi_req.wdata;
      n.ws    = axi_req.wstrb;
    end
    if (n.aw_got && n.w_got && !s.rsp.bvalid) begin
      n.aw_got     = 1'b0;
      n.w_got      = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp  = RESP_OKAY;
      case (n.awa)
        REG_CTRL: begin
          // Commands while busy or booting are dropped, not queued
          if (n.ws[0] && s.st == S_IDLE && s.boot_done &&
              n.wd[2:0] >= CMD_READ && n.wd[2:0] <= CMD_STAT_RD) begin
            n.cmd  = n.wd[2:0];
            n.csel = n.wd[CSEL_BIT];
            n.st   = is_wr(n.wd[2:0]) ? S_LSET : S_MAIN;
          end
        end
        REG_ADDR: begin
          for (int b = 0; b < 3; b++) begin
            if (n.ws[b]) begin
              n.addr[b*8 +: 8] = n.wd[b*8 +: 8];
            end
          end
        end
        REG_WDAT: begin
          if (n.ws[0]) begin
            n.wdat = n.wd[7:0];
          end
        end
        REG_STAT: n.rsp.bresp = RESP_OKAY;
        default:  n.rsp.bresp = RESP_SLVERR;
      endcase
    end
    n.rsp.awready = !n.aw_got && !n.rsp.bvalid;
    n.rsp.wready  = !n.w_got && !n.rsp.bvalid;
    if (s.rsp.rvalid && axi_req.rready) begin
      n.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s.rsp.arready) begin
      n.rsp.rvalid = 1'b1;
      n.rsp.rresp  = RESP_OKAY;
      case (axi_req.araddr)
        REG_CTRL: n.rsp.rdata = {27'h0, s.csel, 1'b0, s.cmd};
        REG_ADDR: n.rsp.rdata = {8'h00, s.addr};
        REG_WDAT: n.rsp.rdata = {24'h0, s.wdat};
        // lock bit visible at bit 15; one status byte
        REG_STAT: n.rsp.rdata = {8'h00, s.rdat, s.stat, 6'h0, s.boot_done, s.st != S_IDLE};
        default: begin
          n.rsp.rdata = 32'h0;
          n.rsp.rresp = RESP_SLVERR;
        end
      endcase
    end
    n.rsp.arready = !n.rsp.rvalid;
  end

  // ********************
  // State register
  // ********************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s           <= '0;
      s.st        <= S_LSET;
      s.pins.cs_n <= 2'b11;
    end else begin
      s <= n;
    end
  end

  assign axi_rsp    = s.rsp;
  assign flash_pins = s.pins;

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  property p_idle_low;
    &s.pins.cs_n |-> !s.pins.sck;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("clock not low while deselected");
  property p_busy_exit;
    s.st == S_PBUSY && n.st == S_IDLE |=> !s.stat[BUSY_BIT] && s.st == S_IDLE;
  endproperty
  a_busy_exit: assert property (p_busy_exit) else $error("left busy poll while busy");
  property p_latch_exit;
    s.st == S_PWEL && n.st != S_PWEL |=> s.stat[LATCH_BIT];
  endproperty
  a_latch_exit: assert property (p_latch_exit) else $error("left latch poll without latch");
  property p_zero_field;
    s.st == S_SWRITE && s.fr_act && s.bidx == 3'h1 |-> !s.pins.mosi;
  endproperty
  a_zero_field: assert property (p_zero_field) else $error("status write data not zero");
  property p_lock_clear;
    $rose(s.st == S_SWRITE && s.fr_act && s.bidx == 3'h1) |-> !s.pins.mosi && s.bitc == 3'h0;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lock bit not cleared first");
  property p_one_byte;
    fend && s.st inside {S_SWRITE, S_PWEL, S_PBUSY} |-> s.bidx == 3'h1;
  endproperty
  a_one_byte: assert property (p_one_byte) else $error("status frame not two bytes");
  property p_boot_only;
    !s.boot_done && s.fr_act |-> s.st inside {S_LSET, S_PWEL, S_SWRITE, S_PBUSY};
  endproperty
  a_boot_only: assert property (p_boot_only) else $error("other frame before unprotect");
  property p_swr_after_latch;
    $rose(s.st == S_SWRITE) |-> $past(s.st) == S_PWEL && !s.boot_done;
  endproperty
  a_swr_after_latch: assert property (p_swr_after_latch) else $error("status write out of order");
  property p_wr_after_latch;
    $rose(s.st == S_MAIN) && is_wr(s.cmd) |-> $past(s.st) == S_PWEL;
  endproperty
  a_wr_after_latch: assert property (p_wr_after_latch) else $error("write without latch poll");
  property p_fast_half;
    s.boot_done && $rose(s.pins.sck) |-> s.pins.sck [*2] ##1 !s.pins.sck;
  endproperty
  a_fast_half: assert property (p_fast_half) else $error("fast clock high phase wrong");
  property p_sel_boot;
    (!s.boot_done |-> s.pins.cs_n[1]) and (s.pins.cs_n != 2'b00);
  endproperty
  a_sel_boot: assert property (p_sel_boot) else $error("wrong select in boot");
  property p_frame_sel;
    (s.fr_act |-> !(&s.pins.cs_n)) and ($rose(&s.pins.cs_n) |-> (&s.pins.cs_n) [*8]);
  endproperty
  a_frame_sel: assert property (p_frame_sel) else $error("select framing broken");
  property p_poll_after;
    fend && s.st == S_MAIN && is_wr(s.cmd) |=> s.st == S_PBUSY;
  endproperty
  a_poll_after: assert property (p_poll_after) else $error("no busy poll after write");

  c_boot:  cover property ($rose(s.boot_done));
  c_read:  cover property (fend && s.st == S_MAIN && s.cmd == CMD_READ);
  c_prog:  cover property (s.st == S_PBUSY && n.st == S_IDLE && s.cmd == CMD_PROG);
  c_erase: cover property (s.st == S_PBUSY && n.st == S_IDLE && s.cmd == CMD_SERASE);
endmodule : sfb_seq

// >>> sfb_flash_model.sv
// Purpose: behavioural serial NOR flash on one select line
// Assumes: mode 0 link, one status byte per status command
// Notes:   latch and busy settle only after a few polls
`timescale 1ns/1ps
module sfb_flash_model #(
  parameter logic [7:0] INIT_STAT = 8'h9C,
  parameter int         LAG       = 2,
  parameter bit         BOOT      = 1'b1
) (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       cs_n,
  output logic            miso,
  output logic [7:0]      stat,
  output int              viol,
  output int              frames,
  output int              half_ns
);
  import sfb_pkg::*;
  logic [7:0]  mem [int];
  logic [7:0]  op;
  logic [7:0]  sh;
  logic [7:0]  wb;
  logic [7:0]  ob;
  logic [23:0] a;
  int          cnt;
  int          wl;
  int          bl;
  realtime     t_up;
  realtime     t_cs;
  // ********************
  // Frame decode
  // ********************
  initial begin
    stat = INIT_STAT;
    miso = 1'b0;
    viol = 0;
    frames = 0;
    cnt = 0;
    wl = 0;
    bl = 0;
  end
  function automatic logic [7:0] out_byte(input int i);
    if (op == OP_STAT_RD)
      return stat;
    if (op == OP_READ && i >= 5)
      return mem.exists(a) ? mem[a] : 8'hFF;
    // Filler changes per byte so stale data never passes
    return ~i[7:0];
  endfunction : out_byte
  task automatic take(input int i);
    if (i == 1) begin
      op = sh;
      if ((op inside {OP_PROG, OP_SERASE, OP_CERASE, OP_STAT_WR} && !stat[LATCH_BIT]) ||
          (op == OP_PROG && stat[6:2] != 5'h00) || (stat[BUSY_BIT] && op != OP_STAT_RD) ||
          (BOOT && frames == 0 && op != OP_LATCH_SET))
        viol++;
    end else if (op == OP_STAT_WR) begin
      if (i == 2)
        wb = sh;
      else
        viol++;
    end else if (i <= 4)
      a = {a[15:0], sh};
    else if (op == OP_PROG && i == 5)
      mem[a] = sh;
  endtask : take
  always @(negedge cs_n) begin
    if (sck !== 1'b0 || (frames > 0 && $realtime - t_cs < DESEL_NS))
      viol++;
    cnt = 0;
    op = 8'h00;
  end
  always @(posedge sck) begin
    t_up = $realtime;
    sh = {sh[6:0], mosi};
    cnt++;
    if (cnt % 8 == 0)
      take(cnt / 8);
  end
  always @(negedge sck) begin
    half_ns = int'($realtime - t_up);
    ob = out_byte(cnt / 8);
    if (!cs_n)
      miso <= #3 ob[7 - cnt % 8];
  end
  always @(posedge cs_n) begin
    // Let clock and select settle, both move at one edge
    #1;
    if (cnt >= 8) begin
      if (sck !== 1'b0)
        viol++;
      frames++;
      t_cs = $realtime;
      miso = ~miso;
      cnt = 0;
      if (op == OP_LATCH_SET)
        wl = LAG;
      else if (op == OP_STAT_RD) begin
        if (wl == 1)
          stat[LATCH_BIT] = 1'b1;
        if (bl == 1)
          stat[1:0] = 2'b00;
        wl = (wl > 0) ? wl - 1 : 0;
        bl = (bl > 0) ? bl - 1 : 0;
      end else if (op != OP_READ) begin
        stat[BUSY_BIT] = 1'b1;
        bl = LAG + 1;
        // field and lock from written byte
        if (op == OP_STAT_WR)
          stat[7:2] = wb[7:2];
        if (op == OP_CERASE)
          mem.delete();
        if (op == OP_SERASE)
          for (int k = 0; k < 4096; k++)
            mem[{a[23:12], 12'h000} + k] = 8'hFF;
      end
    end
  end
endmodule : sfb_flash_model

// >>> sfb_seq_tb.sv
// Purpose: self-checking bench of the serial flash sequencer
// Assumes: AXI4-Lite master here, one flash model per select
// Notes:   short slow divider keeps the boot brief
`timescale 1ns/1ps
module sfb_seq_tb;
  import sfb_pkg::*;
  localparam int SLOW_P = 4;
  localparam int FAST_P = 2;
  typedef struct {
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0]  r;
  } sfb_exp_t;
  logic         clk_sys;
  logic         reset;
  logic         m0;
  logic         m1;
  sfb_axi_req_t req;
  sfb_axi_rsp_t rsp;
  sfb_pins_t    pins;
  logic [7:0]   st0;
  logic [7:0]   st1;
  int           v0, v1, f0, f1, h0, h1, fb;
  int           mismatches;
  int           total_checks;
  logic [31:0]  seed;
  logic [31:0]  rd;
  logic [23:0]  ad;
  logic [7:0]   dt;
  sfb_exp_t     ex;
  sfb_exp_t     rq[$];
  logic [1:0]   wq[$];
  sfb_seq #(.SLOW_HALF_P(SLOW_P), .FAST_HALF_P(FAST_P)) uut (.clk_sys(clk_sys), .reset(reset),
    .axi_req(req), .axi_rsp(rsp), .flash_pins(pins), .miso(pins.cs_n[1] ? m0 : m1));
  sfb_flash_model fl0 (.sck(pins.sck), .mosi(pins.mosi), .cs_n(pins.cs_n[0]), .miso(m0), .stat(st0),
    .viol(v0), .frames(f0), .half_ns(h0));
  sfb_flash_model #(.BOOT(1'b0)) fl1 (.sck(pins.sck), .mosi(pins.mosi), .cs_n(pins.cs_n[1]), .miso(m1),
    .stat(st1), .viol(v1), .frames(f1), .half_ns(h1));
  // ********************
  // Checking and bus tasks
  // ********************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_rd(input logic [31:0] d, input logic [1:0] r, input sfb_exp_t e);
    cmp_val(d & e.m, e.d & e.m, "read data");
    cmp_val({30'h0, r}, {30'h0, e.r}, "read resp");
  endtask : cmp_rd
  task automatic cmp_wr(input logic [1:0] r, input logic [1:0] e);
    cmp_val({30'h0, r}, {30'h0, e}, "write resp");
  endtask : cmp_wr
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    int   n;
    logic aw;
    logic w;
    wq.push_back(r);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= s;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (aw && rsp.awready === 1'b1) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready === 1'b1) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end while (rsp.bvalid !== 1'b1 && n < 100);
    if (n >= 100) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    int n;
    rq.push_back('{d, m, r});
    req.araddr <= a;
    req.arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (rsp.arready === 1'b1)
        req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1 && n < 100);
    rd = rsp.rdata;
    if (n >= 100) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : axi_rd
  task automatic wait_stat(input int b, input logic v);
    int n;
    n = 0;
    do begin
      axi_rd(REG_STAT, 32'h0, 32'h0, RESP_OKAY);
      n++;
    end while (rd[b] !== v && n < 2000);
    if (n >= 2000) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : wait_stat
  task automatic do_cmd(input logic [2:0] c, input logic cs, input logic [23:0] a, input logic [7:0] d);
    axi_wr(REG_ADDR, {8'h00, a}, 4'hF, RESP_OKAY);
    axi_wr(REG_WDAT, {24'h0, d}, 4'h1, RESP_OKAY);
    axi_wr(REG_CTRL, {27'h0, cs, 1'b0, c}, 4'h1, RESP_OKAY);
    wait_stat(0, 1'b0);
  endtask : do_cmd
  // Results are matched in issue order, one per handshake
  always @(posedge clk_sys) begin
    if (rsp.rvalid === 1'b1 && rq.size() > 0) begin
      ex = rq.pop_front();
      cmp_rd(rsp.rdata, rsp.rresp, ex);
    end
    if (rsp.bvalid === 1'b1 && wq.size() > 0)
      cmp_wr(rsp.bresp, wq.pop_front());
  end
  // ********************
  // Main sequence
  // ********************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    reset = 1'b1;
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    mismatches = 0;
    total_checks = 0;
    seed = 32'd34;
    repeat (4) @(posedge clk_sys);
    cmp_val({27'h0, pins, rsp.awready}, 32'h06, "reset pins");
    reset <= 1'b0;
    wait_stat(1, 1'b1);
    cmp_val(st0, 8'h00, "boot status");
    cmp_val(f0, 9, "boot frames");
    cmp_val(h0, SLOW_P * 10, "slow half");
    $display("test boot done");
    axi_rd(4'h2, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    axi_wr(4'h6, 32'h1, 4'hF, RESP_SLVERR);
    axi_wr(REG_STAT, 32'h0, 4'hF, RESP_OKAY);
    fb = f0;
    axi_wr(REG_CTRL, 32'h6, 4'h1, RESP_OKAY);
    axi_wr(REG_CTRL, {29'h0, CMD_STAT_RD}, 4'h0, RESP_OKAY);
    do_cmd(CMD_STAT_RD, 1'b0, 24'h0, 8'h0);
    cmp_val(f0 - fb, 1, "status frames");
    axi_rd(REG_STAT, 32'h0002, 32'hFF03, RESP_OKAY);
    $display("test refusals done");
    for (int i = 0; i < 2; i++) begin
      seed = xs(seed);
      ad = seed[23:0];
      dt = seed[31:24];
      fb = f0;
      do_cmd(CMD_PROG, 1'b0, ad, dt);
      cmp_val(f0 - fb, 9, "program frames");
      do_cmd(CMD_READ, 1'b0, ad, 8'h00);
      axi_rd(REG_STAT, {8'h00, dt, 16'h0002}, 32'h00FFFF03, RESP_OKAY);
    end
    cmp_val(h0, FAST_P * 10, "fast half");
    for (int k = 0; k < 2; k++) begin
      do_cmd(CMD_PROG, 1'b0, ad, 8'h5A);
      do_cmd(k == 0 ? CMD_SERASE : CMD_CERASE, 1'b0, ad ^ 24'h000ABC, 8'h00);
      do_cmd(CMD_READ, 1'b0, ad, 8'h00);
      axi_rd(REG_STAT, 32'h00FF0002, 32'h00FFFF03, RESP_OKAY);
    end
    $display("test program erase done");
    fb = f0;
    do_cmd(CMD_STAT_RD, 1'b1, 24'h0, 8'h0);
    cmp_val(f0 - fb, 0, "boot select idle");
    cmp_val(f1, 1, "second select frames");
    axi_rd(REG_STAT, 32'h9C02, 32'hFF03, RESP_OKAY);
    cmp_val(v0 + v1, 0, "link faults");
    $display("test second select done");
    tally_and_finish();
  end
endmodule : sfb_seq_tb
